// [core/cpm_consts.svh]
// Purpose: constants for the control pin and general purpose pin mux
// Assumes: one 10 MHz clock, ports stand in for control registers
// Notes: holds the field positions, reset values and pin counts
// Overview of operation
// - power_down_n at 0 puts the device into power down and stops operation.
// - in power down every cmos output floats and the pll is stopped.
// - power_down_n at 1 enables the device; undriven, a pull-down keeps it off.
// - self_test_enable at 0 disables self test and at 1 enables it.
// - in self test, clock select 0 picks the pixel clock and 1 the 33 MHz clock.
// - the clock select terminal doubles as the external interrupt input.
// - back channel pins 0 to 3 leave reset as general purpose, driving low.
// - back channel pins 0 to 3 share audio serial out, word clock, data c, d.
// - fast pins act as general i/o only in two-lane mode; they reset floating.
// - fast pins 0 to 3 share spi data out, data in, clock and slave select.
// - register-only pins 5 and 6 are set by register only and reset low.
// - register-only pins 5 and 6 share audio data outputs b and a.
// - in the alternate role audio terminals a to d are slave-mode outputs.
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH
`define CPM_BC_PINS 4
`define CPM_FAST_PINS 4
`define CPM_REG_PINS 2
`define CPM_SEL_GPIO 1'h0
`define CPM_SEL_ALT 1'h1
`define CPM_OUT_RESET 1'h0
`define CPM_CLKSEL_PIXEL 1'h0
`define CPM_CLKSEL_INTERNAL 1'h1
`define CPM_SPI_MISO_IDX 1
`endif

// [core/cpm_pin_mux.sv]
// Purpose: control pins and shared general purpose pin multiplexing
// Assumes: inputs are synchronous to clock_in; reset_n_in is the async reset
// Notes: back channel and fast pads are in, out and enable, register pads out and enable only; enable high means this side drives
`include "cpm_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cpm_pin_mux #(
	parameter int BC_PINS = `CPM_BC_PINS,
	parameter int FAST_PINS = `CPM_FAST_PINS,
	parameter int REG_PINS = `CPM_REG_PINS
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic power_down_n_in,
	input wire logic self_test_enable_in,
	input wire logic self_test_clock_select_in,
	input wire logic two_lane_mode_in,
	input wire logic [BC_PINS-1:0] bc_select_in,
	input wire logic [BC_PINS-1:0] bc_value_in,
	input wire logic [BC_PINS-1:0] bc_drive_in,
	input wire logic audio_serial_data_out_in,
	input wire logic audio_master_word_clock_in,
	input wire logic audio_data_out_c_in,
	input wire logic audio_data_out_d_in,
	input wire logic [FAST_PINS-1:0] fast_select_in,
	input wire logic [FAST_PINS-1:0] fast_value_in,
	input wire logic [FAST_PINS-1:0] fast_drive_in,
	input wire logic spi_data_out_in,
	input wire logic spi_clock_terminal_in,
	input wire logic spi_slave_select_in,
	input wire logic [REG_PINS-1:0] reg_select_in,
	input wire logic [REG_PINS-1:0] reg_value_in,
	input wire logic audio_data_out_a_in,
	input wire logic audio_data_out_b_in,
	input wire logic [BC_PINS-1:0] bc_pad_in,
	input wire logic [FAST_PINS-1:0] fast_pad_in,
	output logic [BC_PINS-1:0] bc_pad_out,
	output logic [BC_PINS-1:0] bc_pad_oe_out,
	output logic [FAST_PINS-1:0] fast_pad_out,
	output logic [FAST_PINS-1:0] fast_pad_oe_out,
	output logic [REG_PINS-1:0] reg_pad_out,
	output logic [REG_PINS-1:0] reg_pad_oe_out,
	output logic [BC_PINS-1:0] bc_read_out,
	output logic [FAST_PINS-1:0] fast_read_out,
	output logic spi_data_in_out,
	output logic device_enabled_out,
	output logic pll_run_out,
	output logic self_test_active_out,
	output logic self_test_internal_clock_out,
	output logic external_interrupt_out
);
	typedef struct packed {
		cpm_pkg::cpm_power_t power;
		cpm_pkg::cpm_bist_t bist;
		logic irq;
		logic [BC_PINS-1:0] bc_o;
		logic [BC_PINS-1:0] bc_oe;
		logic [BC_PINS-1:0] bc_rd;
		logic [FAST_PINS-1:0] fast_o;
		logic [FAST_PINS-1:0] fast_oe;
		logic [FAST_PINS-1:0] fast_rd;
		logic miso;
		logic [REG_PINS-1:0] reg_o;
		logic [REG_PINS-1:0] reg_oe;
	} cpm_state_t;

	cpm_state_t state_q;
	cpm_state_t state_d;
	logic [BC_PINS-1:0] bc_alt;
	logic [FAST_PINS-1:0] fast_alt;
	logic [REG_PINS-1:0] reg_alt;

	// pick alt or gpio value per terminal
	function automatic logic pick(input logic sel, input logic gpio,
		input logic alt);
		pick = (sel == `CPM_SEL_ALT) ? alt : gpio;
	endfunction

	// alternate sources in terminal order
	assign bc_alt = {audio_data_out_d_in, audio_data_out_c_in,
		audio_master_word_clock_in, audio_serial_data_out_in};
	assign fast_alt = {spi_slave_select_in, spi_clock_terminal_in,
		1'h0, spi_data_out_in};
	assign reg_alt = {audio_data_out_a_in, audio_data_out_b_in};

	// next state: power, self test and the pad muxes
	always_comb begin
		state_d = state_q;
		state_d.power = power_down_n_in ? cpm_pkg::CPM_ON
			: cpm_pkg::CPM_OFF;
		case (state_d.power)
			cpm_pkg::CPM_ON: begin
				if (!self_test_enable_in) begin
					state_d.bist = cpm_pkg::CPM_BIST_OFF;
					// shared terminal reads as interrupt outside self test
					state_d.irq = self_test_clock_select_in;
				end else begin
					state_d.irq = 1'h0;
					state_d.bist = (self_test_clock_select_in ==
						`CPM_CLKSEL_INTERNAL) ? cpm_pkg::CPM_BIST_INTERNAL
						: cpm_pkg::CPM_BIST_PIXEL;
				end
				for (int i = 0; i < BC_PINS; i++) begin
					state_d.bc_o[i] = pick(bc_select_in[i], bc_value_in[i],
						bc_alt[i]);
					// audio alternates are always outputs
					state_d.bc_oe[i] = bc_select_in[i] | bc_drive_in[i];
					state_d.bc_rd[i] = bc_pad_in[i];
				end
				for (int i = 0; i < FAST_PINS; i++) begin
					state_d.fast_o[i] = pick(fast_select_in[i], fast_value_in[i],
						fast_alt[i]);
					if (fast_select_in[i] == `CPM_SEL_ALT) begin
						// spi data in is the only input of the four
						state_d.fast_oe[i] = (i != `CPM_SPI_MISO_IDX);
					end else begin
						state_d.fast_oe[i] = fast_drive_in[i] &
							two_lane_mode_in;
					end
					state_d.fast_rd[i] = two_lane_mode_in ? fast_pad_in[i]
						: 1'h0;
				end
				state_d.miso = fast_pad_in[`CPM_SPI_MISO_IDX];
				for (int i = 0; i < REG_PINS; i++) begin
					state_d.reg_o[i] = pick(reg_select_in[i], reg_value_in[i],
						reg_alt[i]);
					state_d.reg_oe[i] = 1'h1;
				end
			end
			default: begin
				// powered down: all outputs float, pll and self test stop
				state_d.bist = cpm_pkg::CPM_BIST_OFF;
				state_d.irq = 1'h0;
				state_d.bc_o = '0;
				state_d.bc_oe = '0;
				state_d.bc_rd = '0;
				state_d.fast_o = '0;
				state_d.fast_oe = '0;
				state_d.fast_rd = '0;
				state_d.miso = 1'h0;
				state_d.reg_o = '0;
				state_d.reg_oe = '0;
			end
		endcase
	end

	// reset: gpio role, back channel and register pins drive low, fast float
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q.power <= cpm_pkg::CPM_OFF;
			state_q.bist <= cpm_pkg::CPM_BIST_OFF;
			state_q.irq <= 1'h0;
			state_q.bc_o <= '0;
			state_q.bc_oe <= '1;
			state_q.bc_rd <= '0;
			state_q.fast_o <= '0;
			state_q.fast_oe <= '0;
			state_q.fast_rd <= '0;
			state_q.miso <= 1'h0;
			state_q.reg_o <= '0;
			state_q.reg_oe <= '1;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from the state flops
	assign bc_pad_out = state_q.bc_o;
	assign bc_pad_oe_out = state_q.bc_oe;
	assign fast_pad_out = state_q.fast_o;
	assign fast_pad_oe_out = state_q.fast_oe;
	assign reg_pad_out = state_q.reg_o;
	assign reg_pad_oe_out = state_q.reg_oe;
	assign bc_read_out = state_q.bc_rd;
	assign fast_read_out = state_q.fast_rd;
	assign spi_data_in_out = state_q.miso;
	assign device_enabled_out = (state_q.power == cpm_pkg::CPM_ON);
	assign pll_run_out = (state_q.power == cpm_pkg::CPM_ON);
	assign self_test_active_out = (state_q.bist != cpm_pkg::CPM_BIST_OFF);
	assign self_test_internal_clock_out =
		(state_q.bist == cpm_pkg::CPM_BIST_INTERNAL);
	assign external_interrupt_out = state_q.irq;

	// checks beside the logic
	chk_pd_float: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		!power_down_n_in |=> (bc_pad_oe_out == '0 && fast_pad_oe_out == '0
		&& reg_pad_oe_out == '0 && !pll_run_out))
		else $error("outputs driven while powered down");
	chk_pd_enable: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		power_down_n_in |=> device_enabled_out)
		else $error("device not enabled with power_down_n high");
	chk_pd_off: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		$fell(power_down_n_in) |=> !device_enabled_out)
		else $error("device stayed on after power down");
	chk_bist_off: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		!self_test_enable_in |=> !self_test_active_out)
		else $error("self test active while disabled");
	chk_bist_clock: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		(power_down_n_in && self_test_enable_in) |=>
		(self_test_active_out && self_test_internal_clock_out
		== $past(self_test_clock_select_in)))
		else $error("wrong self test clock");
	chk_irq_share: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		(power_down_n_in && !self_test_enable_in) |=>
		external_interrupt_out == $past(self_test_clock_select_in))
		else $error("interrupt does not follow shared pin");
	chk_fast_single: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		(!two_lane_mode_in && fast_select_in == '0) |=>
		fast_pad_oe_out == '0)
		else $error("fast pin driven outside two-lane mode");
	chk_bc_mux: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		(power_down_n_in && bc_select_in[0]) |=>
		(bc_pad_out[0] == $past(audio_serial_data_out_in)
		&& bc_pad_oe_out[0]))
		else $error("audio serial out not on back channel pin 0");
	chk_reg_mux: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		(power_down_n_in && !reg_select_in[1]) |=>
		reg_pad_out[1] == $past(reg_value_in[1]))
		else $error("register pin 6 not following its value");
	cov_bist_int: cover property (@(posedge clock_in)
		self_test_internal_clock_out);
	cov_two_lane: cover property (@(posedge clock_in) fast_pad_oe_out != '0);
	cov_pd_cycle: cover property (@(posedge clock_in)
		device_enabled_out ##1 !device_enabled_out);
endmodule
`default_nettype wire

// [core/cpm_pkg.sv]
// Purpose: types for the control pin mux
// Assumes: constants come from cpm_consts.svh
// Notes: the power state machine has two states
package cpm_pkg;
	typedef enum logic {
		CPM_OFF,
		CPM_ON
	} cpm_power_t;
	typedef enum logic [1:0] {
		CPM_BIST_OFF,
		CPM_BIST_PIXEL,
		CPM_BIST_INTERNAL
	} cpm_bist_t;
endpackage

// [tb/cpm_board.sv]
// Purpose: board side of the shared pads and the power-down pin
// Assumes: the device drives a pad only while its enable is high
// Notes: a released pad takes the board level, never the last device value
`timescale 1ns/10ps
`default_nettype none
module cpm_board (
	input wire logic on_in,
	input wire logic [3:0] bc_pad_in,
	input wire logic [3:0] bc_oe_in,
	input wire logic [3:0] bc_board_in,
	input wire logic [3:0] fast_pad_in,
	input wire logic [3:0] fast_oe_in,
	input wire logic [3:0] fast_board_in,
	output logic power_down_n_out,
	output logic [3:0] bc_level_out,
	output logic [3:0] fast_level_out
);
	// board logic holds the device enabled only while it asks for it
	assign power_down_n_out = on_in;
	// wired pads: whoever enables wins, otherwise the board level shows
	assign bc_level_out = (bc_oe_in & bc_pad_in) | (~bc_oe_in & bc_board_in);
	assign fast_level_out = (fast_oe_in & fast_pad_in)
		| (~fast_oe_in & fast_board_in);
endmodule
`default_nettype wire

// [tb/cpm_pin_mux_tb.sv]
// Purpose: self-checking bench for the control pin and gpio mux
// Assumes: inputs change 10 ns after a rising edge
// Notes: outputs are registered, so checks wait one edge past the cause
`timescale 1ns/10ps
`default_nettype none
module cpm_pin_mux_tb;
	logic clock_in, reset_n_in, on, ste, stc, two;
	logic [3:0] bs, bv, bd, ba, fs, fv, fd, fa, bb, fb;
	logic [1:0] rs, rv, ra;
	wire logic pdn, sdi, en, pll, sta, sti, irq;
	wire logic [3:0] bpo, boe, fpo, foe, bl, fl, brd, frd;
	wire logic [1:0] rpo, roe;
	int num_errors = 0;
	int checks_done = 0;
	// device under test, every input reachable from a scenario
	cpm_pin_mux uut (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.power_down_n_in(pdn), .self_test_enable_in(ste),
		.self_test_clock_select_in(stc), .two_lane_mode_in(two),
		.bc_select_in(bs), .bc_value_in(bv), .bc_drive_in(bd),
		.audio_serial_data_out_in(ba[0]), .audio_master_word_clock_in(ba[1]),
		.audio_data_out_c_in(ba[2]), .audio_data_out_d_in(ba[3]),
		.fast_select_in(fs), .fast_value_in(fv), .fast_drive_in(fd),
		.spi_data_out_in(fa[0]), .spi_clock_terminal_in(fa[2]),
		.spi_slave_select_in(fa[3]), .reg_select_in(rs), .reg_value_in(rv),
		.audio_data_out_a_in(ra[1]), .audio_data_out_b_in(ra[0]),
		.bc_pad_in(bl), .fast_pad_in(fl), .bc_pad_out(bpo),
		.bc_pad_oe_out(boe), .fast_pad_out(fpo), .fast_pad_oe_out(foe),
		.reg_pad_out(rpo), .reg_pad_oe_out(roe), .bc_read_out(brd),
		.fast_read_out(frd), .spi_data_in_out(sdi), .device_enabled_out(en),
		.pll_run_out(pll), .self_test_active_out(sta),
		.self_test_internal_clock_out(sti), .external_interrupt_out(irq));
	cpm_board board (.on_in(on), .bc_pad_in(bpo), .bc_oe_in(boe),
		.bc_board_in(bb), .fast_pad_in(fpo), .fast_oe_in(foe),
		.fast_board_in(fb), .power_down_n_out(pdn), .bc_level_out(bl),
		.fast_level_out(fl));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#10;
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_power();
		on = 1'h0;
		tick(1);
		chk({boe, foe}, 8'h00);
		chk({roe, en, pll}, 8'h00);
		on = 1'h1;
		tick(1);
		chk({en, pll, boe}, 8'h30);
	endtask
	task automatic t_self_test();
		stc = 1'h1;
		tick(1);
		chk({sta, irq}, 8'h01);
		ste = 1'h1;
		tick(1);
		chk({sta, sti, irq}, 8'h06);
		stc = 1'h0;
		tick(1);
		chk({sta, sti, irq}, 8'h04);
	endtask
	task automatic t_bc();
		// one terminal at a time on its audio role, the rest released
		for (int i = 0; i < 4; i++) begin
			bs = 4'h1 << i;
			ba = 4'h1 << i;
			tick(1);
			chk(bpo & boe, 8'h01 << i);
			chk(boe, 8'h01 << i);
		end
		{bs, bd, bv, bb} = 16'h051a;
		tick(2);
		chk({boe, bpo & boe}, 8'h51);
		chk(brd, 8'h0b);
	endtask
	task automatic t_fast();
		{fd, fv, fb} = 12'hf56;
		tick(2);
		chk({foe, frd}, 8'h00);
		two = 1'h1;
		tick(2);
		chk({foe, fpo}, 8'hf5);
		fd = 4'h0;
		tick(2);
		chk(frd, 8'h06);
		{fs, fa} = 8'hfd;
		tick(2);
		chk({foe, fpo & foe}, 8'hdd);
		chk(sdi, 8'h01);
	endtask
	task automatic t_reg();
		{rv, ra} = 4'h9;
		tick(1);
		chk({roe, rpo}, 8'h0e);
		rs = 2'h3;
		tick(1);
		chk({roe, rpo}, 8'h0d);
	endtask
	// 100 ns period
	initial begin
		clock_in = 1'h0;
		forever #50 clock_in = ~clock_in;
	end
	// the scenarios need well under 50 cycles
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
	initial begin
		{reset_n_in, on, ste, stc, two} = 5'h08;
		{bs, bv, bd, ba, fs, fv, fd, fa, bb, fb} = 40'h0;
		{rs, rv, ra} = 6'h0;
		repeat (4) @(posedge clock_in);
		// look off the edge, and keep each compare within eight bits
		#10;
		chk({boe, bpo}, 8'hf0);
		chk(foe, 8'h00);
		chk({roe, rpo}, 8'h0c);
		reset_n_in = 1'h1;
		tick(1);
		t_power();
		t_self_test();
		t_bc();
		t_fast();
		t_reg();
		print_verdict();
	end
endmodule
`default_nettype wire
